/* rtl/i2cmte_pkg.sv */
package i2cmte_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned RELOAD_W   = 7;
  localparam int unsigned RS_RELOAD_W = 6;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned CTL2_W     = 8;
  localparam int unsigned STAT_W     = 8;
  localparam int unsigned SEQ_W      = 5;
  localparam int unsigned PHASE_W    = 2;
  localparam int unsigned BITCNT_W   = 4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTL2_START_POS   = 0;
  localparam int unsigned CTL2_RESTART_POS = 1;
  localparam int unsigned CTL2_ACK_STATUS_BIT_POS = 6;
  localparam int unsigned STAT_BF_POS      = 0;
  localparam int unsigned STAT_START_POS   = 3;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [SEQ_W-1:0]    SEQ_RESET     = 5'h00;
  localparam logic [RELOAD_W-1:0] CNT_RESET     = 7'h00;
  localparam logic [BITCNT_W-1:0] BIT_LAST_DATA = 4'h7;
  localparam logic [BITCNT_W-1:0] BIT_ACK       = 4'h8;
  // Four-phase instruction cycle; the counter steps on phases 1 and 3
  localparam logic [PHASE_W-1:0]  PHASE_RESET   = 2'h0;
  localparam int unsigned         SYNC_STAGES   = 2;
  localparam int unsigned         BUF_DEPTH     = 2;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [11:0] {
    S_IDLE      = 12'h001,
    S_ST_WAIT   = 12'h002,
    S_ST_HOLD   = 12'h004,
    S_RS_LOW    = 12'h008,
    S_RS_SDAHI  = 12'h010,
    S_RS_SCLREL = 12'h020,
    S_RS_HIGH   = 12'h040,
    S_RS_SDALO  = 12'h080,
    S_TX_LOW    = 12'h100,
    S_TX_REL    = 12'h200,
    S_TX_HIGH   = 12'h400,
    S_WAIT_BUF  = 12'h800
  } i2cmte_state_t;

endpackage

/* rtl/i2cmte_sync.sv */
`timescale 1ns/1ns
module i2cmte_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             arst_n_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta   <= '1;
      sync_o <= '1;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

/* rtl/i2cmte_buf.sv */
`timescale 1ns/1ns
module i2cmte_buf #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             arst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

/* rtl/i2cmte_top.sv */
// Summary of operation
// - Released clock pauses counter until seen high
// - Start enable with idle lines reloads counter
// - Lines high at timeout: pull data low
// - Second rollover ends Start, clears enable
// - Start collision: lines low, abort to idle
// - Buffer write during Start sets write collision
// - Sequence bits locked until Start completes
// - Repeated Start: clock low, reload six bits
// - Release clock, hold high, drive data low
// - Start seen early, interrupt after timeout
// - Repeated Start ignored unless sequencer idle
// - Repeated Start collision on data or clock
// - Buffer write during Repeated Start discarded
// - Sequence bits locked until Repeated Start completes
// - Buffer write sets full flag, starts counter
// - Data changes with clock low, stable high
// - Eighth fall clears full flag, releases data
// - Ninth fall samples acknowledge into bit six
// - After ninth clock: interrupt, hold clock low
// - Write during shift flagged; software clears it
// - Address byte shifts out most significant first
// - Counter reloads seven bits, stops at zero
// - Counter steps twice per instruction cycle
`timescale 1ns/1ns
module i2cmte_top
  import i2cmte_pkg::*;
#(
  parameter int unsigned BUF_ENTRIES = i2cmte_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic                              mclk_i,
  input  wire logic                              arst_n_i,
  // Bus pins, open drain
  input  wire logic                              scl_i,
  output logic                                   scl_o,
  output logic                                   scl_oe_o,
  input  wire logic                              sda_i,
  output logic                                   sda_o,
  output logic                                   sda_oe_o,
  // Configuration
  input  wire logic [i2cmte_pkg::RELOAD_W-1:0]   addr_reload_reg_i,
  // Second control register
  input  wire logic                              ctl2_wr_i,
  input  wire logic [i2cmte_pkg::SEQ_W-1:0]      ctl2_wdata_i,
  output logic      [i2cmte_pkg::CTL2_W-1:0]     port_control_two_o,
  // Transmit buffer write
  input  wire logic                              xfer_wr_i,
  input  wire logic [i2cmte_pkg::BYTE_W-1:0]     xfer_data_i,
  output logic                                   xfer_ready_o,
  // Status and flags
  output logic      [i2cmte_pkg::STAT_W-1:0]     port_status_reg_o,
  output logic                                   write_collision_flag_o,
  input  wire logic                              write_collision_flag_clr_i,
  output logic                                   port_irq_flag_o,
  input  wire logic                              irq_clr_i,
  output logic                                   bus_collision_flag_o,
  input  wire logic                              bcl_clr_i,
  output logic                                   idle_o
);

  import i2cmte_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  i2cmte_state_t       state;
  i2cmte_state_t       next_state;
  logic                scl_s;
  logic                sda_s;
  logic                scl_q;
  logic                sda_q;
  logic [PHASE_W-1:0]  phase;
  logic                rate_tick;
  logic [RELOAD_W-1:0] rate_counter;
  logic                rate_run;
  logic                rate_done;
  logic                rate_load;
  logic [RELOAD_W-1:0] load_val;
  logic                scl_drv;
  logic                sda_drv;
  logic                next_scl_drv;
  logic                next_sda_drv;
  logic [SEQ_W-1:0]    seq_bits;
  logic                start_seq_enable;
  logic                restart_seq_enable;
  logic                idle_st;
  logic                seq_busy;
  logic                coll;
  logic                irq_set;
  logic                seq_clr;
  logic                take_byte;
  logic                bit_adv;
  logic                ack_smp;
  logic                bf_clr;
  logic                buffer_full_flag;
  logic                start_seen;
  logic                ack_status_bit;
  logic [BYTE_W-1:0]   shift_register;
  logic [BITCNT_W-1:0] bit_cnt;
  logic                tx_bit;
  logic                wr_ok;
  logic                buf_in_ready;
  logic                buf_push;
  logic                buf_valid;
  logic [BYTE_W-1:0]   buf_data;

  // ----------------------------------------------------------------
  // Pin synchronisers and buffer
  // ----------------------------------------------------------------
  i2cmte_sync #(
    .WIDTH (2)
  ) u_sync (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .async_i  ({scl_i, sda_i}),
    .sync_o   ({scl_s, sda_s})
  );

  i2cmte_buf #(
    .WIDTH (BYTE_W),
    .DEPTH (BUF_ENTRIES)
  ) u_buf (
    .mclk_i      (mclk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (buf_push),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (xfer_data_i),
    .out_valid_o (buf_valid),
    .out_ready_i (take_byte),
    .out_data_o  (buf_data)
  );

  assign start_seq_enable   = seq_bits[CTL2_START_POS];
  assign restart_seq_enable = seq_bits[CTL2_RESTART_POS];
  assign idle_st            = (state == S_IDLE) || (state == S_WAIT_BUF);
  assign seq_busy           = start_seq_enable || restart_seq_enable;
  // At most one byte queues: a byte is accepted only while the engine waits
  assign wr_ok              = idle_st && !seq_busy;
  assign xfer_ready_o       = wr_ok && buf_in_ready;
  assign buf_push           = xfer_wr_i && xfer_ready_o;
  assign tx_bit             = (bit_cnt == BIT_ACK) ? 1'b1 : shift_register[BYTE_W-1];

  // ----------------------------------------------------------------
  // Rate counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase <= PHASE_RESET;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  assign rate_tick = phase[0];
  assign rate_done = rate_run && rate_tick && (rate_counter == CNT_RESET);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rate_counter <= CNT_RESET;
      rate_run     <= 1'b0;
    end else if (rate_load) begin
      rate_counter <= load_val;
      rate_run     <= 1'b1;
    end else if (rate_done || coll) begin
      rate_run     <= 1'b0;
    end else if (rate_run && rate_tick) begin
      rate_counter <= rate_counter - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state   = state;
    next_scl_drv = scl_drv;
    next_sda_drv = sda_drv;
    rate_load    = 1'b0;
    load_val     = addr_reload_reg_i;
    coll         = 1'b0;
    irq_set      = 1'b0;
    seq_clr      = 1'b0;
    take_byte    = 1'b0;
    bit_adv      = 1'b0;
    ack_smp      = 1'b0;
    bf_clr       = 1'b0;
    case (state)
      S_IDLE, S_WAIT_BUF: begin
        if (start_seq_enable) begin
          if (scl_s && sda_s) begin
            rate_load  = 1'b1;
            next_state = S_ST_WAIT;
          end else begin
            coll = 1'b1;
          end
        end else if (restart_seq_enable) begin
          next_scl_drv = 1'b1;
          next_state   = S_RS_LOW;
        end else if (buf_valid) begin
          take_byte    = 1'b1;
          next_scl_drv = 1'b1;
          rate_load    = 1'b1;
          next_state   = S_TX_LOW;
        end
      end
      S_ST_WAIT: begin
        if (!scl_s) begin
          coll = 1'b1;
        end else if (rate_done) begin
          if (sda_s) begin
            next_sda_drv = 1'b1;
            rate_load    = 1'b1;
            next_state   = S_ST_HOLD;
          end else begin
            coll = 1'b1;
          end
        end
      end
      S_ST_HOLD: begin
        if (rate_done) begin
          seq_clr    = 1'b1;
          irq_set    = 1'b1;
          next_state = S_IDLE;
        end
      end
      S_RS_LOW: begin
        if (!scl_s) begin
          rate_load    = 1'b1;
          load_val     = {1'b0, addr_reload_reg_i[RS_RELOAD_W-1:0]};
          next_sda_drv = 1'b0;
          next_state   = S_RS_SDAHI;
        end
      end
      S_RS_SDAHI: begin
        if (rate_done) begin
          if (sda_s) begin
            next_scl_drv = 1'b0;
            next_state   = S_RS_SCLREL;
          end else begin
            coll = 1'b1;
          end
        end
      end
      S_RS_SCLREL: begin
        if (scl_s) begin
          if (!sda_s) begin
            coll = 1'b1;
          end else begin
            rate_load  = 1'b1;
            next_state = S_RS_HIGH;
          end
        end
      end
      S_RS_HIGH: begin
        if (!scl_s || !sda_s) begin
          coll = 1'b1;
        end else if (rate_done) begin
          next_sda_drv = 1'b1;
          rate_load    = 1'b1;
          next_state   = S_RS_SDALO;
        end
      end
      S_RS_SDALO: begin
        if (!scl_s) begin
          coll = 1'b1;
        end else if (rate_done) begin
          seq_clr    = 1'b1;
          irq_set    = 1'b1;
          next_state = S_IDLE;
        end
      end
      S_TX_LOW: begin
        // Data moves only once the clock is really low
        if (!scl_s) begin
          next_sda_drv = !tx_bit;
        end
        if (rate_done) begin
          next_scl_drv = 1'b0;
          next_state   = S_TX_REL;
        end
      end
      S_TX_REL: begin
        if (scl_s) begin
          rate_load  = 1'b1;
          next_state = S_TX_HIGH;
        end
      end
      S_TX_HIGH: begin
        if (rate_done) begin
          next_scl_drv = 1'b1;
          if (bit_cnt == BIT_ACK) begin
            ack_smp      = 1'b1;
            irq_set      = 1'b1;
            next_sda_drv = 1'b0;
            next_state   = S_WAIT_BUF;
          end else begin
            bit_adv    = 1'b1;
            rate_load  = 1'b1;
            bf_clr     = (bit_cnt == BIT_LAST_DATA);
            next_state = S_TX_LOW;
          end
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (coll) begin
      next_scl_drv = 1'b0;
      next_sda_drv = 1'b0;
      seq_clr      = 1'b1;
      rate_load    = 1'b0;
      next_state   = S_IDLE;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
    end else begin
      scl_drv <= next_scl_drv;
      sda_drv <= next_sda_drv;
    end
  end

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_register <= '0;
      bit_cnt        <= '0;
    end else if (take_byte) begin
      shift_register <= buf_data;
      bit_cnt        <= '0;
    end else if (bit_adv) begin
      shift_register <= {shift_register[BYTE_W-2:0], 1'b0};
      bit_cnt        <= bit_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control and status
  // ----------------------------------------------------------------
  // Enables may only be raised while idle; others keep what was written
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seq_bits <= SEQ_RESET;
    end else if (seq_clr) begin
      seq_bits[CTL2_START_POS]   <= 1'b0;
      seq_bits[CTL2_RESTART_POS] <= 1'b0;
    end else if (ctl2_wr_i && !seq_busy) begin
      seq_bits <= ctl2_wdata_i;
      if (!idle_st) begin
        seq_bits[CTL2_START_POS]   <= 1'b0;
        seq_bits[CTL2_RESTART_POS] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      buffer_full_flag <= 1'b0;
    end else if (buf_push) begin
      buffer_full_flag <= 1'b1;
    end else if (bf_clr) begin
      buffer_full_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      write_collision_flag_o <= 1'b0;
    end else if (xfer_wr_i && !xfer_ready_o) begin
      write_collision_flag_o <= 1'b1;
    end else if (write_collision_flag_clr_i) begin
      write_collision_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_irq_flag_o <= 1'b0;
    end else if (irq_set) begin
      port_irq_flag_o <= 1'b1;
    end else if (irq_clr_i) begin
      port_irq_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_collision_flag_o <= 1'b0;
    end else if (coll) begin
      bus_collision_flag_o <= 1'b1;
    end else if (bcl_clr_i) begin
      bus_collision_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_status_bit <= 1'b0;
    end else if (ack_smp) begin
      ack_status_bit <= sda_s;
    end
  end

  // Start seen from the lines, cleared by a stop on the lines
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      start_seen <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      if (scl_s && scl_q && sda_q && !sda_s) begin
        start_seen <= 1'b1;
      end else if (scl_s && scl_q && !sda_q && sda_s) begin
        start_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    port_control_two_o                   = '0;
    port_control_two_o[SEQ_W-1:0]        = seq_bits;
    port_control_two_o[CTL2_ACK_STATUS_BIT_POS] = ack_status_bit;
    port_status_reg_o                    = '0;
    port_status_reg_o[STAT_BF_POS]       = buffer_full_flag;
    port_status_reg_o[STAT_START_POS]    = start_seen;
  end

  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = scl_drv;
  assign sda_oe_o = sda_drv;
  assign idle_o   = idle_st && !seq_busy;

endmodule

/* test/i2cmte_asserts.sv */
`timescale 1ns/1ns
module i2cmte_asserts (
  // Clock and reset
  input wire logic                          mclk_i,
  input wire logic                          arst_n_i,
  // Bus
  input wire logic                          scl_i,
  input wire logic                          sda_i,
  input wire logic                          scl_oe_o,
  input wire logic                          sda_oe_o,
  // Software side
  input wire logic                          ctl2_wr_i,
  input wire logic                          xfer_wr_i,
  input wire logic                          xfer_ready_o,
  input wire logic                          write_collision_flag_clr_i,
  input wire logic [i2cmte_pkg::CTL2_W-1:0] port_control_two_o,
  input wire logic [i2cmte_pkg::STAT_W-1:0] port_status_reg_o,
  input wire logic                          write_collision_flag_o,
  input wire logic                          port_irq_flag_o,
  input wire logic                          bus_collision_flag_o
);
  import i2cmte_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  write_collision_flag_set_a: assert property (
    xfer_wr_i && !xfer_ready_o |=> write_collision_flag_o) else $error("refused write not flagged");
  write_collision_flag_hold_a: assert property (
    write_collision_flag_o && !write_collision_flag_clr_i |=> write_collision_flag_o) else $error("write_collision_flag self-cleared");
  full_set_a: assert property (
    xfer_wr_i && xfer_ready_o |=> port_status_reg_o[0]) else $error("buffer full not set");
  ctl_lock_a: assert property (
    ctl2_wr_i && (|port_control_two_o[1:0]) |=> $stable(port_control_two_o[4:2]))
    else $error("control written mid sequence");
  start_cond_a: assert property (
    $rose(sda_oe_o) && port_control_two_o[0] |-> scl_i ##[1:6] port_status_reg_o[3])
    else $error("start condition wrong");
  start_end_a: assert property (
    $fell(port_control_two_o[0]) && !bus_collision_flag_o |-> sda_oe_o && !scl_oe_o
    ##[0:1] port_irq_flag_o) else $error("start end wrong");
  coll_abort_a: assert property (
    $rose(bus_collision_flag_o) |-> !scl_oe_o && !sda_oe_o && port_control_two_o[1:0] == 2'h0)
    else $error("collision did not abort");
  start_coll_a: assert property (
    $rose(port_control_two_o[0]) && !scl_i && !sda_i |-> ##[1:6] bus_collision_flag_o)
    else $error("low lines not a collision");
  high_time_a: assert property (
    $rose(scl_i) && !scl_oe_o && port_status_reg_o[0] |=> (!scl_oe_o)[*8])
    else $error("clock high too short");
  irq_park_a: assert property (
    $rose(port_irq_flag_o) && !sda_oe_o |=> (scl_oe_o && !sda_oe_o)[*6])
    else $error("clock not parked low");
endmodule

bind i2cmte_top i2cmte_asserts i_i2cmte_asserts (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .scl_i(scl_i), .sda_i(sda_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
  .ctl2_wr_i(ctl2_wr_i), .xfer_wr_i(xfer_wr_i), .xfer_ready_o(xfer_ready_o),
  .write_collision_flag_clr_i(write_collision_flag_clr_i), .port_control_two_o(port_control_two_o),
  .port_status_reg_o(port_status_reg_o), .write_collision_flag_o(write_collision_flag_o),
  .port_irq_flag_o(port_irq_flag_o), .bus_collision_flag_o(bus_collision_flag_o));

/* test/i2cmte_slave.sv */
`timescale 1ns/1ns
module i2cmte_slave (
  // Bus lines
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            scl_pull_o,
  output logic            sda_pull_o,
  // Behaviour and capture
  input  wire logic       ack_en_i,
  input  wire logic       stretch_en_i,
  output logic [7:0]      rx_o
);
  int nr = 0;
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    rx_o = 8'h00;
  end
  // A start restarts the bit count
  always @(negedge sda_i) begin
    if (scl_i) begin
      nr = 0;
    end
  end
  always @(posedge scl_i) begin
    nr = nr + 1;
    if (nr <= 8) begin
      rx_o = {rx_o[6:0], sda_i};
    end
  end
  // Ack slot after the eighth bit; stretching mimics a slow slave
  always @(negedge scl_i) begin
    sda_pull_o = (nr == 8) && ack_en_i;
    if (nr >= 9) begin
      nr = 0;
    end
    if (stretch_en_i) begin
      scl_pull_o = 1'b1;
      #200;
      scl_pull_o = 1'b0;
    end
  end
endmodule

/* test/i2cmte_bench.sv */
`timescale 1ns/1ns
module i2cmte_bench;
  import i2cmte_pkg::*;
  logic              mclk_i = 1'b0;
  logic              arst_n_i, ctl2_wr_i, xfer_wr_i, write_collision_flag_clr_i, irq_clr_i, bcl_clr_i;
  logic              ack_en, stretch_en, tb_sda, s_scl, s_sda;
  logic              scl_oe, sda_oe, write_collision_flag, irq, bcl, rdy, idl;
  logic [SEQ_W-1:0]  ctl2_wdata_i;
  logic [BYTE_W-1:0] xfer_data_i, ctl2, stat, rx;
  wire               scl = !(scl_oe | s_scl);
  wire               sda = !(sda_oe | s_sda | tb_sda);
  int                n_fail = 0;
  int                samples_checked = 0;

  i2cmte_top i_i2cmte_top (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .scl_i(scl), .scl_o(),
    .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .addr_reload_reg_i(7'h04),
    .ctl2_wr_i(ctl2_wr_i), .ctl2_wdata_i(ctl2_wdata_i), .port_control_two_o(ctl2),
    .xfer_wr_i(xfer_wr_i), .xfer_data_i(xfer_data_i), .xfer_ready_o(rdy),
    .port_status_reg_o(stat), .write_collision_flag_o(write_collision_flag), .write_collision_flag_clr_i(write_collision_flag_clr_i),
    .port_irq_flag_o(irq), .irq_clr_i(irq_clr_i), .bus_collision_flag_o(bcl),
    .bcl_clr_i(bcl_clr_i), .idle_o(idl));
  i2cmte_slave i_i2cmte_slave (.scl_i(scl), .sda_i(sda), .scl_pull_o(s_scl),
    .sda_pull_o(s_sda), .ack_en_i(ack_en), .stretch_en_i(stretch_en), .rx_o(rx));

  always #4 mclk_i = ~mclk_i;

  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Edge left between pulses so no signal is driven twice in a step
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_irq();
    for (int k = 0; k < 20000 && irq !== 1'b1; k++) tick();
    chk({7'h0, irq}, 8'h01);
    pulse(irq_clr_i);
    tick(3);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    final_report();
  end

  initial begin
    {arst_n_i, ctl2_wr_i, xfer_wr_i, write_collision_flag_clr_i, irq_clr_i, bcl_clr_i} = 6'h00;
    {stretch_en, tb_sda, ctl2_wdata_i, xfer_data_i} = 15'h0000;
    ack_en = 1'b1;
    tick(2);
    arst_n_i = 1'b1;
    // ------
    // Start with queued work refused
    // ------
    ctl2_wdata_i = 5'h01;
    pulse(ctl2_wr_i);
    xfer_data_i = 8'h3c;
    pulse(xfer_wr_i);
    chk({7'h0, write_collision_flag}, 8'h01);
    ctl2_wdata_i = 5'h1c;
    pulse(ctl2_wr_i);
    chk(ctl2, 8'h01);
    chk({6'h0, idl, rdy}, 8'h00);
    wait_irq();
    chk({4'h0, ctl2[0], stat[3], scl, sda}, 8'h06);
    chk({6'h0, idl, rdy}, 8'h03);
    pulse(write_collision_flag_clr_i);
    // ------
    // Acknowledged byte, refused write and restart
    // ------
    xfer_data_i = 8'ha6;
    pulse(xfer_wr_i);
    chk({7'h0, stat[0]}, 8'h01);
    xfer_data_i = 8'h11;
    pulse(xfer_wr_i);
    ctl2_wdata_i = 5'h02;
    pulse(ctl2_wr_i);
    chk({6'h0, write_collision_flag, ctl2[1]}, 8'h02);
    wait_irq();
    chk(rx, 8'ha6);
    chk({ctl2[6], stat[0], write_collision_flag, 5'h0}, 8'h20);
    pulse(write_collision_flag_clr_i);
    // ------
    // Repeated start, then unacknowledged byte to a stretching slave
    // ------
    pulse(ctl2_wr_i);
    pulse(xfer_wr_i);
    chk({7'h0, write_collision_flag}, 8'h01);
    wait_irq();
    chk({4'h0, ctl2[1], stat[3], scl, sda}, 8'h06);
    ack_en = 1'b0;
    stretch_en = 1'b1;
    xfer_data_i = 8'h5b;
    pulse(xfer_wr_i);
    wait_irq();
    chk(rx, 8'h5b);
    chk({7'h0, ctl2[6]}, 8'h01);
    // ------
    // Start with data line already low
    // ------
    stretch_en = 1'b0;
    tb_sda = 1'b1;
    ctl2_wdata_i = 5'h01;
    pulse(ctl2_wr_i);
    tick(6);
    chk({bcl, ctl2[0], scl_oe, sda_oe, 4'h0}, 8'h80);
    tb_sda = 1'b0;
    pulse(bcl_clr_i);
    final_report();
  end
endmodule
